// ---- rtl/smb_pkg.sv ----
// Constants shared by the bus release logic and its shift engine.
// Assumes one 125 MHz system clock and SPI mode 0 transfers.
package smb_pkg;
    // ****************************************
    // Pin counts and widths
    // ****************************************
    localparam int GP_PIN_COUNT = 9;
    localparam int SPI_BITS = 8;
    localparam logic [3:0] BIT_TOP = 4'h7;
    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_CLK_PERIOD_NS = 8;
    localparam int SCK_HALF_PERIOD_NS = 1000;
    // Least time, so round up
    localparam int SCK_HALF_CYCLES =
        (SCK_HALF_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int DIV_W = 8;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [GP_PIN_COUNT-1:0] CS_IDLE_LEVEL = 9'h1ff;
    localparam logic [SPI_BITS-1:0] RX_RESET = 8'h00;
    // ****************************************
    // Arbitration states
    // ****************************************
    typedef enum logic [1:0] {
        SMB_OWN,
        SMB_XFER,
        SMB_RELEASED
    } smb_state_t;
endpackage : smb_pkg

// ---- rtl/smb_shift_if.sv ----
// Carrier between the arbitration logic and the SPI shift engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface smb_shift_if;
    import smb_pkg::*;
    logic start;
    logic abort;
    logic [SPI_BITS-1:0] tx;
    logic [SPI_BITS-1:0] rx;
    logic busy;
    logic done;
    logic sck;
    logic mosi;
    logic miso;
    modport ctrl (output start, output abort, output tx, output miso,
                  input rx, input busy, input done, input sck, input mosi);
    modport eng (input start, input abort, input tx, input miso,
                 output rx, output busy, output done, output sck, output mosi);
endinterface : smb_shift_if

// ---- rtl/smb_spi_shifter.sv ----
// SPI mode 0 byte shift engine with abort.
// Assumes start arrives only while idle; abort stops at once.
`timescale 1ns/1ps
module smb_spi_shifter #(
    parameter int HALF_CYCLES = smb_pkg::SCK_HALF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    smb_shift_if.eng sif
);
    import smb_pkg::*;
    localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(HALF_CYCLES - 1);
    logic busy_reg;
    logic done_reg;
    logic sck_reg;
    logic mosi_reg;
    logic [SPI_BITS-1:0] sh_reg;
    logic [SPI_BITS-1:0] rx_reg;
    logic [3:0] bit_reg;
    logic [DIV_W-1:0] div_reg;
    wire tick = busy_reg && (div_reg == DIV_TOP);
    wire rise = tick && !sck_reg;
    wire fall = tick && sck_reg;
    wire last = fall && (bit_reg == 4'h0);
    // ****************************************
    // Shifting
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            sh_reg <= RX_RESET;
            rx_reg <= RX_RESET;
            bit_reg <= 4'h0;
            div_reg <= '0;
        end
        else
        begin
            done_reg <= last;
            div_reg <= (!busy_reg || tick) ? '0 : div_reg + 1'b1;
            if (sif.abort)
            begin
                busy_reg <= 1'b0;
                sck_reg <= 1'b0;
            end
            else if (sif.start && !busy_reg)
            begin
                busy_reg <= 1'b1;
                sh_reg <= sif.tx;
                mosi_reg <= sif.tx[SPI_BITS-1];
                bit_reg <= BIT_TOP;
            end
            else if (rise)
            begin
                sck_reg <= 1'b1;
                sh_reg <= {sh_reg[SPI_BITS-2:0], sif.miso};
            end
            else if (fall)
            begin
                sck_reg <= 1'b0;
                mosi_reg <= sh_reg[SPI_BITS-1];
                bit_reg <= bit_reg - 4'h1;
                if (last)
                begin
                    busy_reg <= 1'b0;
                    rx_reg <= sh_reg;
                end
            end
        end
    end
    assign sif.busy = busy_reg;
    assign sif.done = done_reg;
    assign sif.sck = sck_reg;
    assign sif.mosi = mosi_reg;
    assign sif.rx = rx_reg;
endmodule : smb_spi_shifter

// ---- rtl/smb_bus_release.sv ----
// SPI master with shared-bus release handshake and chip select pins.
// Assumes synchronous pin inputs, active-high request, active-low selects.
`timescale 1ns/1ps
module smb_bus_release #(
    parameter int CS_W = smb_pkg::GP_PIN_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic shared_mode_en,
    input wire logic release_pin_dedicated,
    input wire logic ack_pin_dedicated,
    input wire logic irq_pin_dedicated,
    input wire logic bus_release_request_pin,
    input wire logic slave_interrupt_monitor_pin,
    input wire logic [CS_W-1:0] gp_cs_mask,
    input wire logic [CS_W-1:0] cs_select,
    input wire logic xfer_start,
    input wire logic xfer_cancel,
    input wire logic [smb_pkg::SPI_BITS-1:0] xfer_tx,
    input wire logic spi_miso,
    output logic spi_sck_o,
    output logic spi_sck_oe,
    output logic spi_mosi_o,
    output logic spi_mosi_oe,
    output logic [CS_W-1:0] general_purpose_pin_o,
    output logic [CS_W-1:0] general_purpose_pin_oe,
    output logic bus_release_ack_pin_o,
    output logic bus_release_ack_pin_oe,
    output logic slave_irq_o,
    output logic xfer_pending_o,
    output logic xfer_busy_o,
    output logic xfer_done_o,
    output logic [smb_pkg::SPI_BITS-1:0] xfer_rx_o,
    output logic bus_released_o
);
    import smb_pkg::*;
    smb_shift_if sif ();
    smb_state_t state_reg;
    smb_state_t state_next;
    logic pend_reg;
    logic [SPI_BITS-1:0] tx_reg;
    logic [CS_W-1:0] sel_reg;
    logic [CS_W-1:0] cs_out_reg;
    logic [CS_W-1:0] cs_oe_reg;
    logic drive_reg;
    logic ack_reg;
    logic ack_oe_reg;
    logic irq_reg;
    logic done_reg;
    logic [SPI_BITS-1:0] rx_reg;
    // ****************************************
    // Decode
    // ****************************************
    wire release_req = shared_mode_en && release_pin_dedicated
                       && bus_release_request_pin;
    wire in_own = (state_reg == SMB_OWN);
    wire in_xfer = (state_reg == SMB_XFER);
    wire in_rel = (state_reg == SMB_RELEASED);
    wire abort_now = in_xfer && release_req && xfer_cancel;
    wire launch = in_own && !release_req && pend_reg;
    // A start landing on the launch edge queues again rather than vanish
    wire pend_next = (pend_reg && !launch) || xfer_start;
    wire take_tx = xfer_start && (!pend_reg || launch);
    wire [CS_W-1:0] sel_next = launch ? (gp_cs_mask & cs_select) : sel_reg;
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            SMB_OWN:
                if (release_req)
                    state_next = SMB_RELEASED;
                else if (pend_reg)
                    state_next = SMB_XFER;
            SMB_XFER:
                if (abort_now)
                    state_next = SMB_RELEASED;
                else if (sif.done)
                    state_next = release_req ? SMB_RELEASED : SMB_OWN;
            SMB_RELEASED:
                if (!release_req)
                    state_next = SMB_OWN;
        endcase
    end
    // Selects and pin drive follow the next state so they move with it
    wire in_xfer_next = (state_next == SMB_XFER);
    wire rel_next = (state_next == SMB_RELEASED);
    wire [CS_W-1:0] cs_out_next = in_xfer_next ? ~sel_next : CS_IDLE_LEVEL[CS_W-1:0];
    wire [CS_W-1:0] cs_oe_next = rel_next ? '0 : gp_cs_mask;
    assign sif.start = launch;
    assign sif.abort = abort_now;
    assign sif.tx = tx_reg;
    assign sif.miso = spi_miso;
    // ****************************************
    // State and pins
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= SMB_OWN;
            pend_reg <= 1'b0;
            tx_reg <= RX_RESET;
            sel_reg <= '0;
            cs_out_reg <= CS_IDLE_LEVEL[CS_W-1:0];
            cs_oe_reg <= '0;
            drive_reg <= 1'b0;
            ack_reg <= 1'b0;
            ack_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
            done_reg <= 1'b0;
            rx_reg <= RX_RESET;
        end
        else
        begin
            state_reg <= state_next;
            pend_reg <= pend_next;
            tx_reg <= take_tx ? xfer_tx : tx_reg;
            sel_reg <= sel_next;
            cs_out_reg <= cs_out_next;
            cs_oe_reg <= cs_oe_next;
            drive_reg <= !rel_next;
            ack_reg <= rel_next;
            ack_oe_reg <= shared_mode_en && ack_pin_dedicated;
            irq_reg <= irq_pin_dedicated && slave_interrupt_monitor_pin;
            done_reg <= sif.done;
            rx_reg <= sif.done ? sif.rx : rx_reg;
        end
    end
    smb_spi_shifter u_shift (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sif(sif)
    );
    assign spi_sck_o = sif.sck;
    assign spi_mosi_o = sif.mosi;
    assign spi_sck_oe = drive_reg;
    assign spi_mosi_oe = drive_reg;
    assign general_purpose_pin_o = cs_out_reg;
    assign general_purpose_pin_oe = cs_oe_reg;
    assign bus_release_ack_pin_o = ack_reg;
    assign bus_release_ack_pin_oe = ack_oe_reg;
    assign slave_irq_o = irq_reg;
    assign xfer_pending_o = pend_reg;
    assign xfer_busy_o = sif.busy;
    assign xfer_done_o = done_reg;
    assign xfer_rx_o = rx_reg;
    assign bus_released_o = ack_reg;
    // ****************************************
    // Coverage helpers
    // ****************************************
    // Request cycles seen mid transfer; a delay range that long is too slow
    logic [11:0] hold_cnt_reg;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            hold_cnt_reg <= '0;
        else if (in_xfer && release_req)
            hold_cnt_reg <= (hold_cnt_reg == 12'hfff) ? hold_cnt_reg : hold_cnt_reg + 12'h001;
        else
            hold_cnt_reg <= '0;
    end
    // ****************************************
    // Checks
    // ****************************************
    a_float_released: assert property (@(posedge sys_clk) disable iff (!rst_b)
        in_rel |-> !spi_sck_oe && !spi_mosi_oe && (general_purpose_pin_oe == '0))
        else $error("bus driven while released");
    a_ack_after_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(ack_reg) |-> $past(release_req) && !sif.busy && in_rel)
        else $error("ack raised before transfer ended");
    a_finish_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (in_xfer && release_req && !xfer_cancel && !sif.done) |=> in_xfer)
        else $error("bus given up mid transfer");
    a_cancel_aborts: assert property (@(posedge sys_clk) disable iff (!rst_b)
        abort_now |=> in_rel && !sif.busy ##1 !spi_sck_oe)
        else $error("cancel did not abort");
    a_ack_drops: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (in_rel && !release_req) |=> in_own ##0 !ack_reg)
        else $error("ack held after request withdrawn");
    a_sole_master: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!release_req && !in_rel) |=> !in_rel)
        else $error("released without a request");
    a_cs_active: assert property (@(posedge sys_clk) disable iff (!rst_b)
        in_xfer |-> ((cs_out_reg & sel_reg) == '0))
        else $error("select not active during transfer");
    a_hold_new: assert property (@(posedge sys_clk) disable iff (!rst_b)
        in_rel |-> !sif.busy && !launch)
        else $error("transfer started while released");
    a_irq_seen: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (irq_pin_dedicated && slave_interrupt_monitor_pin) |=> slave_irq_o)
        else $error("slave interrupt not observed");
    a_ack_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (shared_mode_en && ack_pin_dedicated) |=> bus_release_ack_pin_oe)
        else $error("ack pin not driven");
    a_idle_selects: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !in_xfer |-> (cs_out_reg == CS_IDLE_LEVEL[CS_W-1:0]))
        else $error("select active outside transfer");
    a_sole_no_ack: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!shared_mode_en && !in_rel) |=> !bus_release_ack_pin_o)
        else $error("ack raised as sole master");
    a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        xfer_done_o |=> !xfer_done_o)
        else $error("done held longer than one cycle");
    c_release_mid: cover property (@(posedge sys_clk) disable iff (!rst_b)
        in_rel && (hold_cnt_reg > 12'h001));
    c_cancel: cover property (@(posedge sys_clk) disable iff (!rst_b) abort_now);
    c_queued_resume: cover property (@(posedge sys_clk) disable iff (!rst_b)
        in_rel && pend_reg ##[1:50] launch);
    c_done_seen: cover property (@(posedge sys_clk) disable iff (!rst_b) xfer_done_o);
    c_idle_release: cover property (@(posedge sys_clk) disable iff (!rst_b)
        in_own && release_req && !pend_reg);
endmodule : smb_bus_release

// ---- bench/smb_partner.sv ----
// Other bus master plus one echo slave on the shared SPI lines.
// Assumes the bench drives want off the clock edge.
`timescale 1ns/1ps
module smb_partner (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic want,
    input wire logic ack,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [7:0] slave_byte,
    output logic req,
    output logic ext_drive,
    output logic ext_sck,
    output logic miso
);
    logic [7:0] sr_reg;
    logic sck_reg;
    // ****************************************
    // Release handshake
    // ****************************************
    // Drives only once acknowledged, never on request alone
    assign ext_drive = req & ack;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req <= 1'b0;
            ext_sck <= 1'b0;
        end
        else
        begin
            req <= want;
            ext_sck <= ext_drive ? ~ext_sck : 1'b0;
        end
    end
    // ****************************************
    // Echo slave
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        sck_reg <= sck;
        if (cs_n)
            sr_reg <= slave_byte;
        else if (sck_reg && !sck)
            sr_reg <= {sr_reg[6:0], sr_reg[7]};
    end
    // Deselected line shows the inverse of the loaded top bit, not the bit itself
    assign miso = cs_n ? ~sr_reg[7] : sr_reg[7];
endmodule : smb_partner

// ---- bench/smb_bus_release_tb_top.sv ----
// Self-checking bench for the shared-bus release block.
// Assumes one 125 MHz clock and the partner model beside it.
`timescale 1ns/1ps
module smb_bus_release_tb_top;
    import smb_pkg::*;
    logic sys_clk, rst_b, shd, rel_d, ack_d, irq_d, irq_pin, start, cancel, want;
    logic [8:0] mask, sel, pin_o, pin_oe;
    logic [7:0] tx_b, sb, slave_b, mosi_cap, rx;
    logic sck_o, sck_oe, mosi_o, mosi_oe, ack_o, ack_oe, irq_o, pend, busy, done, rel_o;
    logic req, ext_drive, ext_sck, miso, bus_sck;
    int n_errors, checked, k, cyc, i;
    smb_bus_release dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .shared_mode_en(shd),
        .release_pin_dedicated(rel_d), .ack_pin_dedicated(ack_d), .irq_pin_dedicated(irq_d),
        .bus_release_request_pin(req), .slave_interrupt_monitor_pin(irq_pin),
        .gp_cs_mask(mask), .cs_select(sel), .xfer_start(start), .xfer_cancel(cancel),
        .xfer_tx(tx_b), .spi_miso(miso), .spi_sck_o(sck_o), .spi_sck_oe(sck_oe),
        .spi_mosi_o(mosi_o), .spi_mosi_oe(mosi_oe), .general_purpose_pin_o(pin_o),
        .general_purpose_pin_oe(pin_oe), .bus_release_ack_pin_o(ack_o),
        .bus_release_ack_pin_oe(ack_oe), .slave_irq_o(irq_o), .xfer_pending_o(pend),
        .xfer_busy_o(busy), .xfer_done_o(done), .xfer_rx_o(rx), .bus_released_o(rel_o));
    smb_partner part_u (.sys_clk(sys_clk), .rst_b(rst_b), .want(want), .ack(ack_o & ack_oe),
        .cs_n(pin_o[0] | ~pin_oe[0]), .sck(bus_sck), .slave_byte(slave_b), .req(req),
        .ext_drive(ext_drive), .ext_sck(ext_sck), .miso(miso));
    // Released lines sit at a pull-down level
    assign bus_sck = sck_oe ? sck_o : (ext_drive ? ext_sck : 1'b0);
    // ****************************************
    // Helpers
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge bus_sck) if (sck_oe) mosi_cap <= {mosi_cap[6:0], mosi_o};
    always @(negedge sys_clk) if (ext_drive) check({sck_oe, mosi_oe, |pin_oe}, 0);
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_errors = n_errors + 1;
            conclude();
        end
    end
    function automatic logic [8:0] cs_exp(input logic [8:0] m, input logic [8:0] s);
        return ~(m & s);
    endfunction : cs_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic start_xfer();
        tx_b = 8'($urandom);
        sb = 8'($urandom);
        slave_b = sb;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
    endtask : start_xfer
    task automatic wait_done();
        k = 0;
        while (done !== 1'b1 && k < 2500)
        begin
            @(negedge sys_clk);
            k = k + 1;
        end
    endtask : wait_done
    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wait_n
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        {rst_b, start, cancel, want, irq_pin, tx_b, slave_b, mosi_cap, cyc} = '0;
        {shd, rel_d, ack_d, irq_d} = 4'hf;
        n_errors = 0;
        checked = 0;
        k = $urandom(35);
        mask = 9'($urandom) | 9'h001;
        sel = 9'($urandom) | 9'h001;
        wait_n(20);
        check({sck_oe, mosi_oe, pin_oe, ack_o, pin_o}, 32'h000001ff);
        rst_b = 1'b1;
        wait_n(2);
        for (i = 0; i < 2; i++)
        begin
            start_xfer();
            wait_n(3);
            check(pin_o, cs_exp(mask, sel));
            check(pin_oe, mask);
            wait_done();
            check(done, 1'b1);
            check(rx, sb);
            check(mosi_cap, tx_b);
        end
        $display("test transfer done");
        want = 1'b1;
        wait_n(4);
        check({ack_o, rel_o, sck_oe, mosi_oe, |pin_oe}, 16'h18);
        start_xfer();
        wait_n(20);
        check({busy, pend}, 16'h1);
        want = 1'b0;
        wait_n(4);
        check({ack_o, sck_oe}, 16'h1);
        wait_done();
        check(rx, sb);
        $display("test release idle done");
        start_xfer();
        wait_n(300);
        want = 1'b1;
        wait_n(300);
        check({ack_o, busy}, 16'h1);
        wait_done();
        check(done, 1'b1);
        check(rx, sb);
        wait_n(3);
        check({ack_o, sck_oe}, 16'h2);
        want = 1'b0;
        wait_n(4);
        $display("test release mid done");
        start_xfer();
        wait_n(300);
        cancel = 1'b1;
        wait_n(10);
        check({ack_o, busy}, 16'h1);
        want = 1'b1;
        wait_n(4);
        check({ack_o, busy}, 16'h2);
        cancel = 1'b0;
        wait_done();
        check(k, 2500);
        want = 1'b0;
        wait_n(4);
        $display("test cancel done");
        for (i = 0; i < 8; i++)
        begin
            {ack_d, rel_d, shd} = i[2:0];
            want = 1'b1;
            wait_n(4);
            check(ack_o, shd & rel_d);
            check(ack_oe, shd & ack_d);
            want = 1'b0;
            wait_n(4);
        end
        {shd, rel_d, ack_d} = 3'h7;
        $display("test config done");
        for (i = 0; i < 20; i++)
        begin
            {irq_d, irq_pin} = 2'($urandom);
            wait_n(2);
            check(irq_o, irq_d & irq_pin);
        end
        $display("test irq done");
        conclude();
    end
endmodule : smb_bus_release_tb_top
